// ===== rgic_master_model.sv
// two-wire bus master model that drives the serial pins of the port
`timescale 1ns/1ps

module rgic_master_model
(
  // bus pins
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // ==========================================
  // timing
  // four system clocks per phase is the least the two-flop pin sampling allows
  int half_ns = 40;

  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // ==========================================
  // bit and frame level
  task automatic clk_bit(input logic b, output logic seen);
    #(half_ns / 2);
    sda_pull = ~b;
    #(half_ns / 2);
    scl = 1'b1;
    #(half_ns / 2);
    seen = sda;
    #(half_ns / 2);
    scl = 1'b0;
  endtask

  task automatic start_cond();
    #(half_ns / 2);
    sda_pull = 1'b0;
    #(half_ns / 2);
    scl = 1'b1;
    #(half_ns / 2);
    sda_pull = 1'b1;
    #(half_ns / 2);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    #(half_ns / 2);
    sda_pull = 1'b1;
    #(half_ns / 2);
    scl = 1'b1;
    #(half_ns / 2);
    sda_pull = 1'b0;
    #(half_ns / 2);
  endtask

  // ack_bit low means this side pulls the ninth bit
  task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx,
    output logic nin);
    for (int i = 7; i >= 0; i--)
      clk_bit(tx[i], rx[i]);
    clk_bit(ack_bit, nin);
  endtask
endmodule

// ===== rgic_pkg.sv
// constants and types shared by the regulator serial control port
package rgic_pkg;

  // ==========================================================================
  // register map
  localparam int RGIC_REG_DEPTH = 32;
  localparam int RGIC_IDX_W = 5;
  localparam logic [7:0] RGIC_VSET_ADDR = 8'h11;
  localparam logic [7:0] RGIC_CONVERTER_CONFIG_ADDR = 8'h12;

  // ==========================================================================
  // converter_config field layout and reset values
  localparam int RGIC_EN_AND_BIT = 7;
  localparam int RGIC_AUX_SWITCH_ENABLE_BIT = 5;
  localparam int RGIC_FORCED_MODE_SELECT_LSB = 0;
  localparam logic [7:0] RGIC_CONVERTER_CONFIG_RST = 8'h80;
  localparam logic [7:0] RGIC_VSET_RST = 8'h48;
  localparam logic [7:0] RGIC_OTHER_RST = 8'h00;

  // ==========================================================================
  // forced_mode_select codes
  localparam logic [1:0] RGIC_FM_NORMAL = 2'h0;
  localparam logic [1:0] RGIC_FM_BYPASS = 2'h1;
  localparam logic [1:0] RGIC_FM_PWM = 2'h2;

  // ==========================================================================
  // serial framing
  localparam logic [3:0] RGIC_BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] RGIC_TARGET_ADDR_DFLT = 7'h2a; // arbitrary value

  // ==========================================================================
  // port state machine
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_ADDR = 10'h002,
    ST_ADDR_ACK = 10'h004,
    ST_REG = 10'h008,
    ST_REG_ACK = 10'h010,
    ST_WDATA = 10'h020,
    ST_WDATA_ACK = 10'h040,
    ST_RDATA = 10'h080,
    ST_RACK = 10'h100,
    ST_IGNORE = 10'h200
  } rgic_state_type;

endpackage

// ===== rgic_port.sv
// regulator two-wire serial target port with mode control outputs
//
// Behaviour
// - Device is target only; master clocks everything.
// - Works up to 100 and 400 kbit/s.
// - Bytes shift most significant bit first.
// - Data edges with clock high are start/stop.
// - Data pin released after power-up until needed.
// - Start is falling data with clock high.
// - Start ignored while powering up or disabled.
// - Stop after valid write reconfigures the loop.
// - Transmitter releases after eight; receiver acks ninth.
// - Ack own address, register byte, each data.
// - Address followed by direction: 1 read, 0 write.
// - Own address is a trimmed constant.
// - Pointer advances after each acked data byte.
// - Stop mid-byte or before data discards write.
// - Read via repeated start; pointer advances per ack.
// - Forced mode field; normal is power-up default.
// - Bypass: high side on, other blocks off.
// - No overcurrent protection while in bypass.
// - Aux switch bit, forced open under lockout.
// - Mode code 0x2 forces pwm operation.
// - Enable bit anded with pin; resets to 1.
`timescale 1ns/1ps

module rgic_port
  import rgic_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = RGIC_TARGET_ADDR_DFLT, // trim value
  parameter logic [7:0] VSET_DEFAULT = RGIC_VSET_RST
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // serial pins, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // enable pin and power-up status
  input wire logic chip_enable,
  input wire logic power_up_busy,
  // analog status, synchronous to ref_clk
  input wire logic uvlo_active,
  input wire logic auto_bypass_req,
  // converter control
  output logic converter_on,
  output logic forced_pwm,
  output logic auto_pfm_pwm,
  output logic high_side_on,
  output logic blocks_powered,
  output logic ocp_enable,
  output logic aux_output_connect,
  output logic [7:0] vset,
  output logic loop_reconfig
);

  // ==========================================================================
  // pin synchronisers
  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  logic en_m_r, en_s_r;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      en_m_r <= 1'b0;
      en_s_r <= 1'b0;
    end
    else
    begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
      en_m_r <= chip_enable;
      en_s_r <= en_m_r;
    end
  end

  // ==========================================================================
  // bus event decode
  rgic_state_type state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic rw_r;
  logic have_data_r;
  logic sda_oe_r;
  logic sda_o_r;
  logic loop_reconfig_r;
  logic [7:0] mem_rd [RGIC_REG_DEPTH];

  wire scl_rise = scl_s_r & ~scl_d_r;
  wire scl_fall = ~scl_s_r & scl_d_r;
  wire start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  wire port_live = en_s_r & ~power_up_busy;
  wire byte_done = scl_fall & (bit_cnt_r == RGIC_BITS_PER_BYTE);
  wire addr_hit = (shift_r[7:1] == TARGET_ADDR);
  wire [RGIC_IDX_W-1:0] ptr_idx = ptr_r[RGIC_IDX_W-1:0];
  wire [7:0] rd_byte = mem_rd[ptr_idx];
  wire rd_msb = rd_byte[7];
  wire bus_quiet = port_live & ~start_det & ~stop_det;
  wire stage_we = bus_quiet & (state_r == ST_WDATA_ACK) & scl_fall;
  // only a stop on a byte boundary after a full data byte and ack keeps the write;
  // the stop's own clock rise is shifted in as one bit, so a clean stop sees at most one
  wire commit_ok = port_live & stop_det & (state_r == ST_WDATA)
    & (bit_cnt_r <= 4'h1) & have_data_r;
  wire flush = ~port_live | start_det | stop_det;

  // ==========================================================================
  // target state machine
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      have_data_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (!port_live)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      have_data_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (start_det)
    begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      have_data_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      have_data_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_ADDR, ST_REG, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_r <= {shift_r[6:0], sda_s_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (byte_done)
          begin
            bit_cnt_r <= 4'h0;
            if (state_r == ST_ADDR && !addr_hit)
            begin
              state_r <= ST_IGNORE;
            end
            else
            begin
              sda_oe_r <= 1'b1;
              if (state_r == ST_ADDR)
              begin
                rw_r <= shift_r[0];
                state_r <= ST_ADDR_ACK;
              end
              else if (state_r == ST_REG)
              begin
                state_r <= ST_REG_ACK;
              end
              else
              begin
                state_r <= ST_WDATA_ACK;
              end
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rw_r)
            begin
              tx_r <= rd_byte;
              sda_oe_r <= ~rd_msb;
              state_r <= ST_RDATA;
            end
            else
            begin
              sda_oe_r <= 1'b0;
              state_r <= ST_REG;
            end
          end
        end
        ST_REG_ACK:
        begin
          if (scl_fall)
          begin
            sda_oe_r <= 1'b0;
            ptr_r <= shift_r;
            state_r <= ST_WDATA;
          end
        end
        ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            sda_oe_r <= 1'b0;
            ptr_r <= ptr_r + 8'h01;
            have_data_r <= 1'b1;
            state_r <= ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (scl_rise)
          begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (byte_done)
          begin
            sda_oe_r <= 1'b0;
            bit_cnt_r <= 4'h0;
            state_r <= ST_RACK;
          end
          else if (scl_fall)
          begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe_r <= ~tx_r[6];
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            if (sda_s_r)
            begin
              state_r <= ST_IGNORE; // master ends the read
            end
            else
            begin
              ptr_r <= ptr_r + 8'h01;
            end
          end
          else if (scl_fall)
          begin
            tx_r <= rd_byte;
            sda_oe_r <= ~rd_msb;
            state_r <= ST_RDATA;
          end
        end
        ST_IDLE, ST_IGNORE:
        begin
          sda_oe_r <= 1'b0;
        end
        default:
        begin
          state_r <= ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // register store with write staging
  // writes land in a staging copy and move to the live copy only on a clean stop
  genvar g;
  generate
    for (g = 0; g < RGIC_REG_DEPTH; g++)
    begin : gen_reg
      localparam logic [7:0] RST_VAL = (g == int'(RGIC_VSET_ADDR)) ? VSET_DEFAULT :
        (g == int'(RGIC_CONVERTER_CONFIG_ADDR)) ? RGIC_CONVERTER_CONFIG_RST : RGIC_OTHER_RST;
      logic [7:0] live_r;
      logic [7:0] stage_r;
      logic pend_r;
      wire hit = stage_we & (ptr_idx == RGIC_IDX_W'(g));

      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          live_r <= RST_VAL;
          stage_r <= 8'h00;
          pend_r <= 1'b0;
        end
        else
        begin
          if (commit_ok && pend_r)
          begin
            live_r <= stage_r;
          end
          if (hit)
          begin
            stage_r <= shift_r;
            pend_r <= 1'b1;
          end
          else if (flush)
          begin
            pend_r <= 1'b0;
          end
        end
      end

      assign mem_rd[g] = live_r;
    end
  endgenerate

  // ==========================================================================
  // mode control
  wire [7:0] cfg = mem_rd[RGIC_CONVERTER_CONFIG_ADDR[RGIC_IDX_W-1:0]];
  wire [1:0] forced_mode_select = cfg[RGIC_FORCED_MODE_SELECT_LSB +: 2];
  wire conv_en = en_s_r & cfg[RGIC_EN_AND_BIT];
  wire fm_normal = (forced_mode_select == RGIC_FM_NORMAL);
  wire bypass_nxt = conv_en & ((forced_mode_select == RGIC_FM_BYPASS)
    | (fm_normal & auto_bypass_req));
  wire pwm_nxt = conv_en & (forced_mode_select == RGIC_FM_PWM);
  wire aux_nxt = cfg[RGIC_AUX_SWITCH_ENABLE_BIT] & ~uvlo_active;

  logic converter_on_r, forced_pwm_r, auto_pfm_pwm_r, high_side_on_r;
  logic blocks_powered_r, ocp_enable_r, aux_output_connect_r;
  logic [7:0] vset_r;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      converter_on_r <= 1'b0;
      forced_pwm_r <= 1'b0;
      auto_pfm_pwm_r <= 1'b0;
      high_side_on_r <= 1'b0;
      blocks_powered_r <= 1'b0;
      ocp_enable_r <= 1'b0;
      aux_output_connect_r <= 1'b0;
      vset_r <= VSET_DEFAULT;
      loop_reconfig_r <= 1'b0;
      sda_o_r <= 1'b0;
    end
    else
    begin
      converter_on_r <= conv_en;
      forced_pwm_r <= pwm_nxt;
      auto_pfm_pwm_r <= conv_en & fm_normal;
      high_side_on_r <= bypass_nxt;
      blocks_powered_r <= conv_en & ~bypass_nxt;
      ocp_enable_r <= conv_en & ~bypass_nxt;
      aux_output_connect_r <= aux_nxt;
      vset_r <= mem_rd[RGIC_VSET_ADDR[RGIC_IDX_W-1:0]];
      loop_reconfig_r <= commit_ok;
      sda_o_r <= 1'b0;
    end
  end

  assign sda_o = sda_o_r;
  assign sda_oe = sda_oe_r;
  assign converter_on = converter_on_r;
  assign forced_pwm = forced_pwm_r;
  assign auto_pfm_pwm = auto_pfm_pwm_r;
  assign high_side_on = high_side_on_r;
  assign blocks_powered = blocks_powered_r;
  assign ocp_enable = ocp_enable_r;
  assign aux_output_connect = aux_output_connect_r;
  assign vset = vset_r;
  assign loop_reconfig = loop_reconfig_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  property p_idle_released;
    (state_r == ST_IDLE) |-> !sda_oe_r;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("idle drives sda");

  property p_start_taken;
    start_det && port_live |=> (state_r == ST_ADDR);
  endproperty
  a_start_taken: assert property (p_start_taken) else $error("start missed");

  property p_start_ignored;
    start_det && !port_live |=> (state_r == ST_IDLE) && !sda_oe_r;
  endproperty
  a_start_ignored: assert property (p_start_ignored) else $error("start not ignored");

  property p_reconfig;
    commit_ok |=> loop_reconfig_r ##1 !loop_reconfig_r;
  endproperty
  a_reconfig: assert property (p_reconfig) else $error("reconfig pulse wrong");

  property p_addr_ack;
    bus_quiet && (state_r == ST_ADDR) && byte_done && addr_hit
      |=> sda_oe_r && (state_r == ST_ADDR_ACK);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

  property p_addr_miss;
    bus_quiet && (state_r == ST_ADDR) && byte_done && !addr_hit
      |=> !sda_oe_r && (state_r == ST_IGNORE);
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");

  property p_ptr_step;
    stage_we |=> (ptr_r == $past(ptr_r) + 8'h01);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer not advanced");

  property p_discard;
    stop_det && (state_r == ST_WDATA) && (bit_cnt_r > 4'h1) |=> !loop_reconfig_r;
  endproperty
  a_discard: assert property (p_discard) else $error("partial write kept");

  property p_read_msb;
    bus_quiet && (state_r == ST_ADDR_ACK) && scl_fall && rw_r
      |=> (sda_oe_r == !$past(rd_msb)) && (state_r == ST_RDATA);
  endproperty
  a_read_msb: assert property (p_read_msb) else $error("read msb wrong");

  property p_bypass_ocp;
    conv_en && (forced_mode_select == RGIC_FM_BYPASS) |=> high_side_on_r && !ocp_enable_r;
  endproperty
  a_bypass_ocp: assert property (p_bypass_ocp) else $error("bypass with ocp");

  property p_aux_uvlo;
    uvlo_active |=> !aux_output_connect_r;
  endproperty
  a_aux_uvlo: assert property (p_aux_uvlo) else $error("aux on under lockout");

  property p_pwm;
    pwm_nxt |=> forced_pwm_r && !high_side_on_r;
  endproperty
  a_pwm: assert property (p_pwm) else $error("forced pwm missing");

  property p_pin_off;
    !en_s_r |=> !converter_on_r && (state_r == ST_IDLE);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin low not honoured");

  c_commit: cover property (commit_ok);
  c_read_ack: cover property ((state_r == ST_RACK) && scl_rise && !sda_s_r);
  c_bypass: cover property (high_side_on_r);
  c_miss: cover property (state_r == ST_IGNORE);

endmodule

// ===== rgic_port_test.sv
// self-checking bench for the regulator serial control port
`timescale 1ns/1ps

module rgic_port_test
  import rgic_pkg::*;
;
  localparam logic [6:0] dev_addr = RGIC_TARGET_ADDR_DFLT;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic chip_enable = 1'b1;
  logic power_up_busy = 1'b0;
  logic uvlo_active = 1'b0;
  logic auto_bypass_req = 1'b0;
  logic scl, sda_pull, sda_o, sda_oe, sda;
  logic converter_on, forced_pwm, auto_pfm_pwm, high_side_on;
  logic blocks_powered, ocp_enable, aux_output_connect, loop_reconfig;
  logic [7:0] vset;
  logic [7:0] r0, r1;
  int errors = 0;
  int compares = 0;
  int reconfigs = 0;
  int cut [3] = '{0, 4, 12};
  logic [1:0] codes [4] = '{RGIC_FM_NORMAL, RGIC_FM_PWM, 2'h3, RGIC_FM_BYPASS};
  logic [4:0] exps [4] = '{5'h13, 5'h0b, 5'h03, 5'h04};

  // open-drain wire with pull-up
  assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_pull;

  always #5 ref_clk = ~ref_clk;

  // counted away from the edge that launches the pulse
  always @(negedge ref_clk)
    if (loop_reconfig === 1'b1)
      reconfigs++;

  rgic_port rgic_port_inst (.ref_clk(ref_clk), .resetn(resetn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .chip_enable(chip_enable), .power_up_busy(power_up_busy),
    .uvlo_active(uvlo_active), .auto_bypass_req(auto_bypass_req), .converter_on(converter_on),
    .forced_pwm(forced_pwm), .auto_pfm_pwm(auto_pfm_pwm), .high_side_on(high_side_on),
    .blocks_powered(blocks_powered), .ocp_enable(ocp_enable),
    .aux_output_connect(aux_output_connect), .vset(vset), .loop_reconfig(loop_reconfig));

  rgic_master_model rgic_master_model_inst (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  // ==========================================
  // checking and closing
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic settle();
    repeat (10) @(posedge ref_clk);
    #1;
  endtask

  task automatic mode_chk(input logic [4:0] exp, input logic pwr);
    check("mode", {5'h00, auto_pfm_pwm, forced_pwm, high_side_on}, {5'h00, exp[4:2]});
    if (pwr)
      check("power", {6'h00, blocks_powered, ocp_enable}, {6'h00, exp[1:0]});
  endtask

  task automatic wait_conv(input logic v);
    int n;
    n = 0;
    while (converter_on !== v && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    #1;
    check("converter_on", {7'h00, converter_on}, {7'h00, v});
    if (n == 50)
      end_of_test();
  endtask

  // ==========================================
  // bus access
  task automatic send_addr(input logic rd, input logic [6:0] dev, input logic acked);
    logic [7:0] rx;
    logic nin;
    rgic_master_model_inst.xfer({dev, rd}, 1'b1, rx, nin);
    check("addr ack", {7'h00, nin}, {7'h00, ~acked});
  endtask

  // nbits short of a byte boundary aborts inside a data byte
  task automatic write_frame(input logic [6:0] dev, input logic [7:0] ra,
    input logic [15:0] stream, input int nbits, input logic acked);
    logic [7:0] rx;
    logic nin;
    rgic_master_model_inst.start_cond();
    send_addr(1'b0, dev, acked);
    rgic_master_model_inst.xfer(ra, 1'b1, rx, nin);
    check("reg ack", {7'h00, nin}, {7'h00, ~acked});
    for (int i = 0; i < nbits; i++)
    begin
      rgic_master_model_inst.clk_bit(stream[15 - i], nin);
      if (i % 8 == 7)
      begin
        rgic_master_model_inst.clk_bit(1'b1, nin);
        check("data ack", {7'h00, nin}, {7'h00, ~acked});
      end
    end
    rgic_master_model_inst.stop_cond();
    settle();
  endtask

  task automatic reg_read(input logic [7:0] ra, input int n, output logic [7:0] d0,
    output logic [7:0] d1);
    logic [7:0] rx;
    logic nin;
    rgic_master_model_inst.start_cond();
    send_addr(1'b0, dev_addr, 1'b1);
    rgic_master_model_inst.xfer(ra, 1'b1, rx, nin);
    rgic_master_model_inst.start_cond();
    send_addr(1'b1, dev_addr, 1'b1);
    rgic_master_model_inst.xfer(8'hff, n == 1, d0, nin);
    if (n > 1)
      rgic_master_model_inst.xfer(8'hff, 1'b1, d1, nin);
    rgic_master_model_inst.stop_cond();
    settle();
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    wait_conv(1'b1);
    settle();
    check("vset", vset, RGIC_VSET_RST);
    mode_chk(5'h13, 1'b1);
    check("sda_oe", {7'h00, sda_oe}, 8'h00);
    $display("test reset defaults done");
    // one write at the fast-mode rate, then back to the quick rate
    rgic_master_model_inst.half_ns = 1250;
    write_frame(dev_addr, RGIC_VSET_ADDR, 16'h3000, 8, 1'b1);
    rgic_master_model_inst.half_ns = 40;
    check("vset", vset, 8'h30);
    check("reconfig", reconfigs[7:0], 8'h01);
    reg_read(RGIC_VSET_ADDR, 1, r0, r1);
    check("read", r0, 8'h30);
    check("sda idle", {7'h00, sda}, 8'h01);
    $display("test single write and read done");
    write_frame(dev_addr, RGIC_VSET_ADDR, 16'h5582, 16, 1'b1);
    check("vset", vset, 8'h55);
    mode_chk(5'h0b, 1'b1);
    reg_read(RGIC_VSET_ADDR, 2, r0, r1);
    check("read0", r0, 8'h55);
    check("read1", r1, 8'h82);
    $display("test block write and read done");
    // reads end on a nack, so only the two committed writes have pulsed
    for (int k = 0; k < 3; k++)
    begin
      write_frame(dev_addr, RGIC_VSET_ADDR, 16'h1122, cut[k], 1'b1);
      check("vset", vset, 8'h55);
      check("reconfig", reconfigs[7:0], 8'h02);
      mode_chk(5'h0b, 1'b1);
    end
    $display("test aborted writes done");
    for (int k = 0; k < 3; k++)
    begin
      @(posedge ref_clk);
      #1;
      chip_enable = (k != 1);
      power_up_busy = (k == 2);
      wait_conv(k != 1);
      write_frame((k == 0) ? (dev_addr ^ 7'h01) : dev_addr, RGIC_VSET_ADDR, 16'h6600, 8,
        1'b0);
      check("vset", vset, 8'h55);
      @(posedge ref_clk);
      #1;
      chip_enable = 1'b1;
      power_up_busy = 1'b0;
      wait_conv(1'b1);
      settle();
    end
    $display("test refused starts done");
    // converter off before the aux switch closes
    write_frame(dev_addr, RGIC_CONVERTER_CONFIG_ADDR, 16'h0000, 8, 1'b1);
    wait_conv(1'b0);
    write_frame(dev_addr, RGIC_CONVERTER_CONFIG_ADDR, 16'h2000, 8, 1'b1);
    write_frame(dev_addr, RGIC_CONVERTER_CONFIG_ADDR, 16'ha000, 8, 1'b1);
    wait_conv(1'b1);
    check("aux", {7'h00, aux_output_connect}, 8'h01);
    uvlo_active = 1'b1;
    settle();
    check("aux", {7'h00, aux_output_connect}, 8'h00);
    uvlo_active = 1'b0;
    settle();
    check("aux", {7'h00, aux_output_connect}, 8'h01);
    $display("test aux switch done");
    auto_bypass_req = 1'b1;
    settle();
    check("auto bypass", {6'h00, high_side_on, ocp_enable}, 8'h02);
    auto_bypass_req = 1'b0;
    // bypass comes last so no quick toggle back out is needed
    for (int k = 0; k < 4; k++)
    begin
      write_frame(dev_addr, RGIC_CONVERTER_CONFIG_ADDR, {6'h28, codes[k], 8'h00}, 8, 1'b1);
      mode_chk(exps[k], 1'b1);
    end
    $display("test forced modes done");
    end_of_test();
  end
endmodule
